/* verilog/dutbi_params.svh */
// Purpose: Constants for the disk unit tag bus interface
// Assumes: 40 MHz hclk
// Notes:   Offsets are byte addresses on the AHB-Lite register port
`ifndef DUTBI_PARAMS_SVH
`define DUTBI_PARAMS_SVH

// Timing
`define DUTBI_CLK_MHZ          40
`define DUTBI_SEEK_TMO_MS      500
`define DUTBI_DD_TMO_MS        575
`define DUTBI_SEEK_TMO_CYC     (`DUTBI_SEEK_TMO_MS * 1000 * `DUTBI_CLK_MHZ)
`define DUTBI_DD_TMO_CYC       (`DUTBI_DD_TMO_MS * 1000 * `DUTBI_CLK_MHZ)
`define DUTBI_TMO_W            25

// Bus widths and limits
`define DUTBI_BUS_W            10
`define DUTBI_MASK_SD          10'h1ff
`define DUTBI_MASK_DD          10'h3ff
`define DUTBI_HEAD_LAST        5'h12

// Control word bit positions
`define DUTBI_CB_WRITE         0
`define DUTBI_CB_READ          1
`define DUTBI_CB_FWD           2
`define DUTBI_CB_HADV          3
`define DUTBI_CB_ERASE         4
`define DUTBI_CB_REV           5
`define DUTBI_CB_RTZ           6
`define DUTBI_CB_EARLY         7
`define DUTBI_CB_LATE          8

// Interlock bit positions
`define DUTBI_IL_SECBLK        1
`define DUTBI_IL_PSTEMP        7
`define DUTBI_IL_LOGTEMP       8
`define DUTBI_IL_CTLIL         9

// Register offsets
`define DUTBI_OFS_CTRL         8'h00
`define DUTBI_OFS_SECTORS      8'h04
`define DUTBI_OFS_SECLEN       8'h08
`define DUTBI_OFS_STEPLEN      8'h0c
`define DUTBI_OFS_INTLK        8'h10
`define DUTBI_OFS_STATUS       8'h14
`define DUTBI_OFS_DIFF         8'h18

// Field positions
`define DUTBI_CTRL_DD          0
`define DUTBI_CTRL_STALL       1
`define DUTBI_ST_HEAD_LSB      16
`define DUTBI_ST_SEEKING       24
`define DUTBI_ST_SEEKERR       25
`define DUTBI_ST_ONCYL         26
`define DUTBI_ST_ONSEC         27
`define DUTBI_ST_FWDOFF        28
`define DUTBI_ST_REVOFF        29
`define DUTBI_DF_TGT_LSB       16

// Reset values
`define DUTBI_CTRL_RST         2'h0
`define DUTBI_SECTORS_RST      5'h18
`define DUTBI_SECLEN_RST       16'h0100
`define DUTBI_STEPLEN_RST      16'h0040
`define DUTBI_INTLK_RST        10'h000

`endif

/* verilog/dutbi_pkg.sv */
// Purpose: Types for the disk unit tag bus interface
// Assumes: dutbi_params.svh supplies widths
// Notes:   State of each module is one packed struct
`include "dutbi_params.svh"

package dutbi_pkg;

   typedef enum logic [1:0] {
      DUTBI_IDLE,
      DUTBI_SEEK,
      DUTBI_RTZ
   } dutbi_seek_t;

   typedef logic [`DUTBI_BUS_W-1:0] dutbi_word_t;

   typedef struct packed {
      logic [`DUTBI_TMO_W-1:0] cnt;
      logic                    expired;
   } dutbi_tmr_t;

   typedef struct packed {
      dutbi_seek_t seek_st;
      logic        dir_rev;
      dutbi_word_t diff;
      dutbi_word_t target;
      dutbi_word_t cyl;
      logic [4:0]  sector;
      logic [4:0]  head;
      logic [4:0]  cur_sec;
      logic [15:0] tick;
      logic [15:0] step_cnt;
      logic        armed;
      logic        on_sector;
      logic        seek_error;
      logic        on_cyl;
      logic        fwd_off;
      logic        rev_off;
      logic        wr_en;
      logic        rd_en;
      logic        er_en;
      logic        early;
      logic        late;
      dutbi_word_t ctl_prev;
      dutbi_word_t status;
      logic [1:0]  ctrl;
      logic [4:0]  sectors;
      logic [15:0] seclen;
      logic [15:0] steplen;
      dutbi_word_t intlk;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      logic        hready;
      logic        hresp;
   } dutbi_state_t;

endpackage

/* verilog/dutbi_seek_timer.sv */
// Purpose: Seek timeout counter
// Assumes: run stays high for the whole move
// Notes:   Restarts from zero whenever run drops
`timescale 1ns/1ps
`include "dutbi_params.svh"

module dutbi_seek_timer #(
   parameter int SEEK_TMO_CYC = `DUTBI_SEEK_TMO_CYC,
   parameter int DD_TMO_CYC   = `DUTBI_DD_TMO_CYC
) (
   input  logic hclk,
   input  logic hresetn,
   input  logic run,
   input  logic dd_mode,
   output logic expired
);
   import dutbi_pkg::*;

   dutbi_tmr_t              st_r;
   dutbi_tmr_t              st_nxt;
   logic [`DUTBI_TMO_W-1:0] limit;

   always_comb begin
      st_nxt = st_r;
      // Double density units use the longer nominal limit
      limit = dd_mode ? DD_TMO_CYC[`DUTBI_TMO_W-1:0] : SEEK_TMO_CYC[`DUTBI_TMO_W-1:0];
      if (!run) begin
         st_nxt.cnt     = '0;
         st_nxt.expired = 1'b0;
      end else if (st_r.cnt >= limit - 1'b1) begin
         st_nxt.expired = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expired = st_r.expired;

endmodule

/* verilog/dutbi_unit.sv */
// Purpose: Unit-side logic of the controller to disk unit tag bus
// Assumes: Tag, select and bus inputs synchronous to hclk
// Notes:   Mechanics are modelled by software-set step and sector lengths
`timescale 1ns/1ps
`include "dutbi_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Bus is nine lines, ten with double density.
// - Difference tag loads the bus as a cylinder distance count.
// - Cylinder tag stores the bus as the target cylinder.
// - Sector tag stores five-bit sector giving the next sector alert.
// - Head tag loads five-bit head number selecting the active head.
// - Control bit 0 enables write driver, bit 1 read data.
// - Bit 2 seeks forward if difference nonzero, else forward offset.
// - Bit 5 seeks reverse if difference nonzero, else reverse offset.
// - Bit 3 increments the head counter.
// - Head advance at end of cylinder clears head counter instead.
// - Bit 4 enables erase driver, ignored in double density.
// - Bit 6 seeks to cylinder zero and clears seek error.
// - Bit 7 moves strobe early, bit 8 moves strobe late.
// - Alert one sector per turn until read, clear or release.
// - Sector alert held off while a seek runs.
// - Seek error on move timeout or travel outside the field.
// - Return to zero ends at cylinder zero, on cylinder.
// - Cylinder select returns the cylinder register.
// - Interlock select puts interlock bits on status bus.
// - Head select returns the head register.
// - Difference select returns the inverted difference.
// - Status bus nine or ten lines, content by select line.
// - Double density uses the 575 ms seek timeout.
module dutbi_unit #(
   parameter int SEEK_TMO_CYC = `DUTBI_SEEK_TMO_CYC,
   parameter int DD_TMO_CYC   = `DUTBI_DD_TMO_CYC
) (
   input  logic               hclk,
   input  logic               hresetn,
   // AHB-Lite slave
   input  logic               hsel,
   input  logic [31:0]        haddr,
   input  logic [1:0]         htrans,
   input  logic               hwrite,
   input  logic [2:0]         hsize,
   input  logic [31:0]        hwdata,
   input  logic               hready,
   output logic               hreadyout,
   output logic [31:0]        hrdata,
   output logic               hresp,
   // Address and control bus with tags
   input  dutbi_pkg::dutbi_word_t ctl_bus,
   input  logic               tag_difference,
   input  logic               tag_cylinder,
   input  logic               tag_sector,
   input  logic               tag_head,
   input  logic               tag_control,
   input  logic               unit_clear,
   input  logic               unit_release,
   // Status selects and status bus
   input  logic               sel_read_cyl,
   input  logic               sel_read_diff,
   input  logic               sel_read_head,
   input  logic               sel_interlock,
   output dutbi_pkg::dutbi_word_t status_bus,
   // Unselected status and drivers
   output logic               on_sector,
   output logic               seek_error,
   output logic               on_cylinder,
   output logic               write_driver_en,
   output logic               read_data_en,
   output logic               erase_driver_en,
   output logic               strobe_early,
   output logic               strobe_late,
   output logic               fwd_offset,
   output logic               rev_offset
);
   import dutbi_pkg::*;

   dutbi_state_t st_r;
   dutbi_state_t st_nxt;
   dutbi_word_t  mask;
   dutbi_word_t  bus_m;
   dutbi_word_t  ctl_g;
   dutbi_word_t  rise;
   dutbi_word_t  il_view;
   logic [4:0]   next_sec;
   logic         dd;
   logic         stall;
   logic         tmo;
   logic         step_due;
   logic         seeking;
   logic         eoc;
   logic         addr_ok;
   logic         return_to_cylinder_zero_cmd;

   dutbi_seek_timer #(
      .SEEK_TMO_CYC (SEEK_TMO_CYC),
      .DD_TMO_CYC   (DD_TMO_CYC)
   ) u_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (seeking),
      .dd_mode (dd),
      .expired (tmo)
   );

   /////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   assign dd       = st_r.ctrl[`DUTBI_CTRL_DD];
   assign stall    = st_r.ctrl[`DUTBI_CTRL_STALL];
   assign seeking  = (st_r.seek_st != DUTBI_IDLE);
   assign eoc      = (st_r.head > `DUTBI_HEAD_LAST);
   assign mask     = dd ? `DUTBI_MASK_DD : `DUTBI_MASK_SD;
   assign bus_m    = ctl_bus & mask;
   // Untagged words never reach the decoders
   assign ctl_g    = tag_control ? bus_m : '0;
   assign rise     = ctl_g & ~st_r.ctl_prev;
   assign step_due = seeking && !stall && (st_r.step_cnt >= st_r.steplen - 1'b1);
   assign next_sec = (st_r.cur_sec >= st_r.sectors - 1'b1) ? 5'h00 : st_r.cur_sec + 1'b1;
   assign addr_ok  = hsel && htrans[1] && hready;
   assign return_to_cylinder_zero_cmd = rise[`DUTBI_CB_RTZ];

   // Double density moves control interlock to bit 1 and logic temp to bit 7
   always_comb begin
      il_view = st_r.intlk & `DUTBI_MASK_SD;
      if (dd) begin
         il_view[`DUTBI_IL_SECBLK]  = st_r.intlk[`DUTBI_IL_CTLIL];
         il_view[`DUTBI_IL_PSTEMP]  = st_r.intlk[`DUTBI_IL_LOGTEMP];
         il_view[`DUTBI_IL_LOGTEMP] = 1'b0;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt          = st_r;
      st_nxt.ctl_prev = ctl_g;

      // Levels follow the tagged control word
      st_nxt.wr_en = ctl_g[`DUTBI_CB_WRITE];
      st_nxt.rd_en = ctl_g[`DUTBI_CB_READ];
      st_nxt.er_en = ctl_g[`DUTBI_CB_ERASE] & ~dd;
      st_nxt.early = ctl_g[`DUTBI_CB_EARLY];
      st_nxt.late  = ctl_g[`DUTBI_CB_LATE];

      // Address loads
      if (tag_difference) begin
         st_nxt.diff = bus_m;
      end
      if (tag_cylinder) begin
         st_nxt.target = bus_m;
      end
      if (tag_sector) begin
         st_nxt.sector = bus_m[4:0];
      end
      if (tag_head) begin
         st_nxt.head = bus_m[4:0];
      end else if (rise[`DUTBI_CB_HADV]) begin
         if (eoc) begin
            st_nxt.head = 5'h00;
         end else begin
            st_nxt.head = st_r.head + 1'b1;
         end
      end

      // Positioner stepping
      if (seeking && !stall) begin
         st_nxt.step_cnt = step_due ? 16'h0000 : st_r.step_cnt + 1'b1;
      end
      if (step_due) begin
         if (st_r.seek_st == DUTBI_RTZ) begin
            if (st_r.cyl == 10'h000) begin
               st_nxt.seek_st = DUTBI_IDLE;
               st_nxt.on_cyl  = 1'b1;
            end else begin
               st_nxt.cyl = st_r.cyl - 1'b1;
            end
         end else if ((!st_r.dir_rev && st_r.cyl == mask) || (st_r.dir_rev && st_r.cyl == 10'h000)) begin
            // Stepping past either end leaves the recording field
            st_nxt.seek_st    = DUTBI_IDLE;
            st_nxt.seek_error = 1'b1;
         end else begin
            st_nxt.cyl  = st_r.dir_rev ? st_r.cyl - 1'b1 : st_r.cyl + 1'b1;
            st_nxt.diff = st_r.diff - 1'b1;
            if (st_r.diff <= 10'h001) begin
               st_nxt.seek_st = DUTBI_IDLE;
               st_nxt.on_cyl  = 1'b1;
            end
         end
      end

      // A new seek command overrides a move
      if (rise[`DUTBI_CB_FWD] || rise[`DUTBI_CB_REV]) begin
         st_nxt.fwd_off = 1'b0;
         st_nxt.rev_off = 1'b0;
         if (st_r.diff != 10'h000) begin
            st_nxt.seek_st  = DUTBI_SEEK;
            st_nxt.dir_rev  = rise[`DUTBI_CB_REV];
            st_nxt.on_cyl   = 1'b0;
            st_nxt.step_cnt = 16'h0000;
         end else if (rise[`DUTBI_CB_REV]) begin
            st_nxt.rev_off = 1'b1;
         end else begin
            st_nxt.fwd_off = 1'b1;
         end
      end
      if (return_to_cylinder_zero_cmd) begin
         st_nxt.seek_error = 1'b0;
         st_nxt.seek_st    = DUTBI_RTZ;
         st_nxt.diff       = 10'h000;
         st_nxt.on_cyl     = 1'b0;
         st_nxt.fwd_off    = 1'b0;
         st_nxt.rev_off    = 1'b0;
         st_nxt.step_cnt   = 16'h0000;
      end
      // Timeout set comes last so it wins over a same-cycle clear
      if (tmo && seeking) begin
         st_nxt.seek_st    = DUTBI_IDLE;
         st_nxt.seek_error = 1'b1;
      end

      // Sector timing and alert
      if (st_r.tick >= st_r.seclen - 1'b1) begin
         st_nxt.tick    = 16'h0000;
         st_nxt.cur_sec = next_sec;
      end else begin
         st_nxt.tick = st_r.tick + 1'b1;
      end
      if (rise[`DUTBI_CB_READ] || unit_clear || unit_release) begin
         st_nxt.armed = 1'b0;
      end
      if (tag_sector) begin
         st_nxt.armed = 1'b1;
      end
      // High for the whole sector before the addressed one
      st_nxt.on_sector = st_r.armed && (next_sec == st_r.sector) && !seeking;

      // Status bus, one select expected at a time
      if (sel_read_cyl) begin
         st_nxt.status = st_r.target & mask;
      end else if (sel_read_diff) begin
         st_nxt.status = ~st_r.diff & mask;
      end else if (sel_read_head) begin
         st_nxt.status = {5'h00, st_r.head};
      end else if (sel_interlock) begin
         st_nxt.status = il_view;
      end else begin
         st_nxt.status = 10'h000;
      end

      // AHB-Lite data phase write
      if (st_r.wr_pend) begin
         if (st_r.wr_addr == `DUTBI_OFS_CTRL) begin
            st_nxt.ctrl = hwdata[1:0];
         end else if (st_r.wr_addr == `DUTBI_OFS_SECTORS) begin
            st_nxt.sectors = (hwdata[4:0] == 5'h00) ? 5'h01 : hwdata[4:0];
         end else if (st_r.wr_addr == `DUTBI_OFS_SECLEN) begin
            st_nxt.seclen = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
         end else if (st_r.wr_addr == `DUTBI_OFS_STEPLEN) begin
            st_nxt.steplen = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
         end else if (st_r.wr_addr == `DUTBI_OFS_INTLK) begin
            st_nxt.intlk = hwdata[9:0];
         end
      end

      // Address phase; read data captured here, zero wait
      st_nxt.wr_pend = addr_ok && hwrite;
      st_nxt.wr_addr = {haddr[7:2], 2'b00};
      if (addr_ok && !hwrite) begin
         if (haddr[7:0] == `DUTBI_OFS_CTRL) begin
            st_nxt.hrdata = {30'h0000_0000, st_r.ctrl};
         end else if (haddr[7:0] == `DUTBI_OFS_SECTORS) begin
            st_nxt.hrdata = {27'h000_0000, st_r.sectors};
         end else if (haddr[7:0] == `DUTBI_OFS_SECLEN) begin
            st_nxt.hrdata = {16'h0000, st_r.seclen};
         end else if (haddr[7:0] == `DUTBI_OFS_STEPLEN) begin
            st_nxt.hrdata = {16'h0000, st_r.steplen};
         end else if (haddr[7:0] == `DUTBI_OFS_INTLK) begin
            st_nxt.hrdata = {22'h00_0000, st_r.intlk};
         end else if (haddr[7:0] == `DUTBI_OFS_STATUS) begin
            st_nxt.hrdata                      = {22'h00_0000, st_r.cyl};
            st_nxt.hrdata[`DUTBI_ST_HEAD_LSB+:5] = st_r.head;
            st_nxt.hrdata[`DUTBI_ST_SEEKING]   = seeking;
            st_nxt.hrdata[`DUTBI_ST_SEEKERR]   = st_r.seek_error;
            st_nxt.hrdata[`DUTBI_ST_ONCYL]     = st_r.on_cyl;
            st_nxt.hrdata[`DUTBI_ST_ONSEC]     = st_r.on_sector;
            st_nxt.hrdata[`DUTBI_ST_FWDOFF]    = st_r.fwd_off;
            st_nxt.hrdata[`DUTBI_ST_REVOFF]    = st_r.rev_off;
         end else if (haddr[7:0] == `DUTBI_OFS_DIFF) begin
            st_nxt.hrdata                       = {22'h00_0000, st_r.diff};
            st_nxt.hrdata[`DUTBI_DF_TGT_LSB+:10] = st_r.target;
         end else begin
            st_nxt.hrdata = 32'h0000_0000;
         end
      end
      st_nxt.hready = 1'b1;
      st_nxt.hresp  = 1'b0;
   end

   /////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r         <= '0;
         st_r.seek_st <= DUTBI_IDLE;
         st_r.on_cyl  <= 1'b1;
         st_r.ctrl    <= `DUTBI_CTRL_RST;
         st_r.sectors <= `DUTBI_SECTORS_RST;
         st_r.seclen  <= `DUTBI_SECLEN_RST;
         st_r.steplen <= `DUTBI_STEPLEN_RST;
         st_r.intlk   <= `DUTBI_INTLK_RST;
         st_r.hready  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register

   assign hreadyout       = st_r.hready;
   assign hrdata          = st_r.hrdata;
   assign hresp           = st_r.hresp;
   assign status_bus      = st_r.status;
   assign on_sector       = st_r.on_sector;
   assign seek_error      = st_r.seek_error;
   assign on_cylinder     = st_r.on_cyl;
   assign write_driver_en = st_r.wr_en;
   assign read_data_en    = st_r.rd_en;
   assign erase_driver_en = st_r.er_en;
   assign strobe_early    = st_r.early;
   assign strobe_late     = st_r.late;
   assign fwd_offset      = st_r.fwd_off;
   assign rev_offset      = st_r.rev_off;

endmodule

/* verification/dutbi_ctl_model.sv */
// Purpose: Controller side of the tag and status select lines
// Assumes: Bench calls put, drop and sel from one process
// Notes:   Bus shows the inverse of the last word outside a tag
`timescale 1ns/1ps
module dutbi_ctl_model (
   input  logic       hclk,
   output logic [9:0] ctl_bus,
   output logic [6:0] tags,
   output logic [3:0] sels
);
   import dutbi_pkg::*;
   initial {ctl_bus, tags, sels} = '0;
   // One tag at a time, word steady for the whole tag
   task automatic put(input logic [6:0] t, input dutbi_word_t v);
      @(posedge hclk);
      ctl_bus <= v;
      tags <= t;
      repeat (2) @(posedge hclk);
   endtask
   // Inverted word exposes untagged sampling
   task automatic drop();
      tags <= '0;
      @(posedge hclk);
      ctl_bus <= ~ctl_bus;
   endtask
   task automatic sel(input logic [3:0] s);
      @(posedge hclk);
      sels <= s;
      repeat (2) @(posedge hclk);
   endtask
endmodule

/* verification/dutbi_unit_checker.sv */
// Purpose: Port level checks of the unit
// Assumes: Bound to every dutbi_unit
// Notes:   Checks are port relations only
`timescale 1ns/1ps
module dutbi_unit_checker (
   input logic       hclk,
   input logic       hresetn,
   input logic       hreadyout,
   input logic       hresp,
   input logic [9:0] ctl_bus,
   input logic       tag_control,
   input logic       sel_read_cyl,
   input logic       sel_read_diff,
   input logic       sel_read_head,
   input logic       sel_interlock,
   input logic [9:0] status_bus,
   input logic       on_sector,
   input logic       seek_error,
   input logic       on_cylinder,
   input logic       write_driver_en,
   input logic       read_data_en,
   input logic       erase_driver_en,
   input logic       strobe_early,
   input logic       strobe_late,
   input logic       fwd_offset,
   input logic       rev_offset
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire any_sel = sel_read_cyl | sel_read_diff | sel_read_head | sel_interlock;
   ////////////////////////////////////////////////////////////////////////////////
   property p_gates;
      {write_driver_en, read_data_en} == $past({tag_control & ctl_bus[0], tag_control & ctl_bus[1]});
   endproperty
   a_gates: assert property (p_gates) else $error("gate mismatch");
   property p_erase;
      erase_driver_en |-> $past(tag_control & ctl_bus[4]);
   endproperty
   a_erase: assert property (p_erase) else $error("stray erase");
   property p_strobe;
      $rose(strobe_early) || $rose(strobe_late) |-> $past(tag_control) && !(strobe_early && strobe_late);
   endproperty
   a_strobe: assert property (p_strobe) else $error("stray strobe");
   property p_nosel;
      $past(!any_sel) |-> status_bus == '0;
   endproperty
   a_nosel: assert property (p_nosel) else $error("stray status");
   property p_head;
      $past(sel_read_head & !sel_read_cyl & !sel_read_diff) |-> status_bus[9:5] == 5'h00;
   endproperty
   a_head: assert property (p_head) else $error("wide head");
   property p_offs;
      !(fwd_offset && rev_offset);
   endproperty
   a_offs: assert property (p_offs) else $error("two offsets");
   property p_oncyl;
      $fell(on_cylinder) |-> $past(tag_control & (ctl_bus[2] | ctl_bus[5] | ctl_bus[6]));
   endproperty
   a_oncyl: assert property (p_oncyl) else $error("stray seek");
   property p_seekerr;
      $rose(seek_error) |-> !on_cylinder;
   endproperty
   a_seekerr: assert property (p_seekerr) else $error("error on cylinder");
   property p_rtz;
      $rose(tag_control & ctl_bus[6]) && seek_error |=> !seek_error;
   endproperty
   a_rtz: assert property (p_rtz) else $error("error kept");
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("bus not okay");
   c_offset: cover property ($rose(fwd_offset));
   c_error: cover property ($rose(seek_error));
   c_alert: cover property ($rose(on_sector));
endmodule
bind dutbi_unit dutbi_unit_checker dutbi_unit_checker_inst (.*);

/* verification/tb.sv */
// Purpose: Directed bench of the unit through bus and tag lines
// Assumes: Seek timeouts cut to 200 and 300 cycles
// Notes:   Sector and step lengths set to 4 to keep turns short
`timescale 1ns/1ps
module tb;
   import dutbi_pkg::*;
   localparam int SD_TMO = 200;
   localparam int DD_TMO = 300;
   localparam logic [6:0] T_DIF = 7'h01, T_CYL = 7'h02, T_SEC = 7'h04, T_HEAD = 7'h08;
   localparam logic [6:0] T_CTL = 7'h10, T_CLR = 7'h20, T_REL = 7'h40;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   dutbi_word_t ctl_bus, status_bus;
   logic [6:0]  tags;
   logic [3:0]  sels;
   logic        on_sector, seek_error, on_cylinder, wr_en, rd_en, er_en, st_e, st_l, fwd, rev;
   int          error_cnt, checks, n, m;
   int          cb [5] = '{0, 1, 4, 7, 8};
   logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h40};
   logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0018, 32'h0000_0100, 32'h0000_0040,
                           32'h0400_0000, 32'h0000_0000};
   logic [6:0]  dt [3] = '{T_CTL, T_CLR, T_REL};
   wire  [4:0]  gates = {st_l, st_e, er_en, rd_en, wr_en};
   dutbi_ctl_model cm (.*);
   dutbi_unit #(.SEEK_TMO_CYC(SD_TMO), .DD_TMO_CYC(DD_TMO)) dutbi_unit_inst (
      .hsize(3'h2), .hready(hreadyout), .tag_difference(tags[0]), .tag_cylinder(tags[1]),
      .tag_sector(tags[2]), .tag_head(tags[3]), .tag_control(tags[4]), .unit_clear(tags[5]),
      .unit_release(tags[6]), .sel_read_cyl(sels[0]), .sel_read_diff(sels[1]),
      .sel_read_head(sels[2]), .sel_interlock(sels[3]), .write_driver_en(wr_en),
      .read_data_en(rd_en), .erase_driver_en(er_en), .strobe_early(st_e), .strobe_late(st_l),
      .fwd_offset(fwd), .rev_offset(rev), .*);
   initial begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic pulse(input logic [6:0] t, input dutbi_word_t v);
      cm.put(t, v);
      cm.drop();
   endtask
   task automatic st(input logic [3:0] s, input logic [31:0] e);
      cm.sel(s);
      chk("status bus", status_bus, e);
      cm.sel(4'h0);
   endtask
   task automatic wcyl();
      for (int i = 0; i < 400 && on_cylinder !== 1'b1; i++) @(posedge hclk);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // Stall freezes the carriage; only the timer ends the move
   task automatic tmo(input logic [31:0] c, input int lim);
      ahb(1, 8'h00, c | 32'h2);
      pulse(T_DIF, 10'h001);
      pulse(T_CTL, 10'h004);
      repeat (lim - 40) @(posedge hclk);
      chk("early error", seek_error, 0);
      repeat (60) @(posedge hclk);
      chk("seek error", seek_error, 1);
      ahb(1, 8'h00, c);
      pulse(T_CTL, 10'h040);
      chk("error cleared", seek_error, 0);
      wcyl();
      chk("on cylinder", on_cylinder, 1);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge hclk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, error_cnt, checks, m} = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      hsel <= 1;
      ahb(1, 8'h14, 32'hffff_ffff);
      foreach (ra[i]) begin
         ahb(0, ra[i], 0);
         chk("reset value", q, rv[i]);
      end
      done("reset");
      ahb(1, 8'h08, 4);
      ahb(1, 8'h0c, 4);
      ahb(1, 8'h04, 4);
      foreach (cb[i]) begin
         cm.put(T_CTL, 10'h001 << cb[i]);
         chk("gate level", gates, 5'h01 << i);
         cm.drop();
         @(posedge hclk);
         chk("gate release", gates, 0);
      end
      ahb(1, 8'h00, 1);
      cm.put(T_CTL, 10'h010);
      chk("erase in dd", er_en, 0);
      cm.drop();
      pulse(T_CYL, 10'h3ff);
      st(4'h1, 10'h3ff);
      ahb(1, 8'h00, 0);
      pulse(T_CYL, 10'h3ff);
      st(4'h1, 10'h1ff);
      done("cylinder");
      pulse(T_HEAD, 10'h3f2);
      st(4'h4, 10'h012);
      pulse(T_CTL, 10'h008);
      st(4'h4, 10'h013);
      pulse(T_CTL, 10'h008);
      st(4'h4, 10'h000);
      done("head");
      pulse(T_DIF, 10'h003);
      st(4'h2, 10'h1fc);
      pulse(T_CTL, 10'h004);
      chk("seeking", on_cylinder, 0);
      wcyl();
      ahb(0, 8'h14, 0);
      chk("forward seek", q[9:0], 10'h003);
      pulse(T_CTL, 10'h004);
      chk("forward offset", {rev, fwd}, 2'b01);
      pulse(T_CTL, 10'h020);
      chk("reverse offset", {rev, fwd}, 2'b10);
      pulse(T_DIF, 10'h002);
      pulse(T_CTL, 10'h020);
      wcyl();
      ahb(0, 8'h14, 0);
      chk("reverse seek", q[9:0], 10'h001);
      chk("no offset", {rev, fwd}, 2'b00);
      pulse(T_CTL, 10'h040);
      wcyl();
      ahb(0, 8'h14, 0);
      chk("return to zero", q[9:0], 10'h000);
      done("seek");
      tmo(0, SD_TMO);
      tmo(1, DD_TMO);
      ahb(1, 8'h00, 0);
      done("timeout");
      for (int k = 0; k < 3; k++) begin
         pulse(T_SEC, 10'h002);
         n = 0;
         // Skip an alert already under way so a whole one is measured
         while (on_sector === 1'b1) @(posedge hclk);
         for (int i = 0; i < 40 && on_sector !== 1'b1; i++) @(posedge hclk);
         while (on_sector === 1'b1 && n < 20) begin
            n++;
            @(posedge hclk);
         end
         chk("alert length", n, 4);
         pulse(dt[k], k == 0 ? 10'h002 : 10'h000);
         repeat (4) @(posedge hclk);
         n = 0;
         repeat (40) begin
            @(posedge hclk);
            n += on_sector;
         end
         chk("disarmed alert", n, 0);
      end
      pulse(T_SEC, 10'h002);
      pulse(T_DIF, 10'h008);
      pulse(T_CTL, 10'h004);
      for (int i = 0; i < 400 && on_cylinder !== 1'b1; i++) begin
         @(posedge hclk);
         m += on_sector;
      end
      chk("seek alert", m, 0);
      done("sector alert");
      ahb(1, 8'h10, 32'h0000_02aa);
      st(4'h8, 10'h0aa);
      ahb(1, 8'h00, 1);
      st(4'h8, 10'h02a);
      done("interlock");
      print_verdict();
   end
endmodule
